// file: logic/black_level_calibration.sv
// Black level calibration: threshold and offset registers with the automatic engine.
`timescale 1ns/1ps
`default_nettype none
module black_level_calibration
    import blc_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [15:0]      reg_wdata,
    output logic      [15:0]      reg_rdata,
    // Sensor sequencing
    input  wire logic             frame_start,
    input  wire logic             dark_rows_start,
    input  wire logic             adc_active,
    input  wire logic             gain_change,
    input  wire logic             timing_change,
    input  wire logic [6:0]       max_gain,
    // Dark pixel stream
    input  wire logic             dark_valid,
    input  wire logic [1:0]       dark_chan,
    input  wire logic [9:0]       dark_pixel,
    // Offset stage
    output logic      [3:0][8:0]  chan_offset,
    output logic                  offset_enable
);

    // ------------------------------------------------------------------
    // Sign-magnitude helpers
    // ------------------------------------------------------------------
    function automatic logic [8:0] step_offset(input logic [8:0] v, input logic up,
                                               input logic [7:0] step);
        logic signed [10:0] s;
        logic signed [10:0] lim;
        s   = v[SIGN_BIT] ? -$signed({3'b000, v[7:0]}) : $signed({3'b000, v[7:0]});
        lim = $signed({1'b0, MAG_LIMIT});
        s   = up ? s + $signed({3'b000, step}) : s - $signed({3'b000, step});
        if (s > lim) begin
            s = lim;
        end else if (s < -lim) begin
            s = -lim;
        end
        step_offset = (s < 0) ? {1'b1, 8'(-s)} : {1'b0, 8'(s)};
    endfunction : step_offset

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [15:0]      thresh_reg;
    logic [15:0]      ctrl_reg;
    logic [3:0][8:0]  prog_offset;
    logic             restart_req;
    logic [15:0]      sh_thresh;
    logic [3:0][8:0]  sh_offset;
    logic [5:0]       floor_lim;
    logic [6:0]       ceil_lim;

    wire        sel_thresh = (reg_addr == THRESH_ADDR);
    wire        sel_ctrl   = (reg_addr == CTRL_ADDR);
    wire [3:0]  sel_offset;
    logic [15:0] next_rdata;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_reg
            assign sel_offset[g] = (reg_addr == OFFSET_ADDR[g]);
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    prog_offset[g] <= OFFSET_RESET;
                end else if (reg_wr && sel_offset[g]) begin
                    prog_offset[g] <= reg_wdata[8:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            thresh_reg  <= THRESH_RESET;
            ctrl_reg    <= CTRL_RESET;
            restart_req <= 1'b0;
        end else begin
            if (reg_wr && sel_thresh) begin
                thresh_reg <= reg_wdata;
            end
            if (reg_wr && sel_ctrl) begin
                ctrl_reg <= {reg_wdata[15:13], 1'b0, reg_wdata[11:0]};
            end
            restart_req <= reg_wr && sel_ctrl && reg_wdata[RESTART_BIT];
        end
    end

    // Threshold reads show the limits in force; offset reads show the programmed values.
    always_comb begin
        next_rdata = 16'h0000;
        if (sel_thresh) begin
            next_rdata = {thresh_reg[NO_GAIN_BIT], ceil_lim, thresh_reg[OVERRIDE_BIT],
                          1'b0, floor_lim};
        end else if (sel_ctrl) begin
            next_rdata = ctrl_reg;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (sel_offset[i]) begin
                    next_rdata = {7'h00, prog_offset[i]};
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Programmed threshold and offset values are copied only as the dark rows begin, so a frame in flight
    // keeps the threshold and offsets it started with; control register bits act at once.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sh_thresh <= THRESH_RESET;
            sh_offset <= '0;
        end else if (dark_rows_start) begin
            sh_thresh <= thresh_reg;
            sh_offset <= prog_offset;
        end
    end

    // ------------------------------------------------------------------
    // Threshold limits
    // ------------------------------------------------------------------
    wire        override   = sh_thresh[OVERRIDE_BIT];
    wire        no_gain    = sh_thresh[NO_GAIN_BIT];
    wire [5:0]  prog_floor = sh_thresh[FLOOR_LSB +: 6];
    wire [6:0]  prog_ceil  = sh_thresh[CEIL_LSB +: 7];
    wire [6:0]  floor_sum  = {1'b0, prog_floor} + {4'h0, max_gain[6:4]};
    wire [5:0]  next_floor = (override || no_gain) ? prog_floor
                           : (floor_sum[6] ? 6'h3f : floor_sum[5:0]);
    wire [6:0]  ceil_base  = (no_gain && !override) ? prog_ceil
                           : 7'({1'b0, floor_lim} + CEIL_MARGIN);

    // ------------------------------------------------------------------
    // Restart and sweep sequencing
    // ------------------------------------------------------------------
    wire     restart     = restart_req || timing_change || gain_change;
    wire     sweep_start = restart_req || timing_change ||
                           (gain_change && !ctrl_reg[NO_SWEEP_BIT]);
    sweep_e  sweep_state;
    sweep_e  next_sweep;
    wire     sweep_on    = (sweep_state == SWEEP_RUN);
    wire     sweep_done  = sweep_on && frame_start;

    always_comb begin
        case (sweep_state)
            SWEEP_IDLE: next_sweep = sweep_start ? SWEEP_WAIT : SWEEP_IDLE;
            SWEEP_WAIT: next_sweep = dark_rows_start ? SWEEP_RUN : SWEEP_WAIT;
            SWEEP_RUN:  next_sweep = sweep_start ? SWEEP_WAIT
                                   : (frame_start ? SWEEP_IDLE : SWEEP_RUN);
            default:    next_sweep = SWEEP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sweep_state <= SWEEP_IDLE;
        end else begin
            sweep_state <= next_sweep;
        end
    end

    // ------------------------------------------------------------------
    // Dark pixel averaging per colour
    // ------------------------------------------------------------------
    logic [3:0]       pend;
    logic [3:0]       first;
    logic [3:0][9:0]  avg_hold;
    logic [3:0]       done;
    logic [3:0]       take;

    generate
        for (g = 0; g < 4; g++) begin : gen_acc
            logic [17:0] sum;
            logic [7:0]  count;
            wire         hit = dark_valid && (dark_chan == 2'(g));
            wire [17:0]  total = sum + {8'h00, dark_pixel};
            assign done[g] = hit && (count == LAST_PIXEL);
            always_ff @(posedge ref_clk) begin
                if (rst || restart) begin
                    sum   <= '0;
                    count <= '0;
                end else if (hit) begin
                    count <= count + 8'h01;
                    sum   <= done[g] ? 18'h00000 : total;
                end
            end
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    pend[g]     <= 1'b0;
                    avg_hold[g] <= '0;
                    first[g]    <= 1'b1;
                end else begin
                    if (done[g]) begin
                        avg_hold[g] <= total[AVG_SHIFT +: 10];
                    end
                    pend[g]  <= done[g] || (pend[g] && !take[g]);
                    first[g] <= restart || (first[g] && !take[g]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Filter and correction engine
    // ------------------------------------------------------------------
    calib_mem_if mbus ();

    calib_store u_store (
        .ref_clk (ref_clk),
        .m       (mbus.mem)
    );

    wire        pick_valid = |pend;
    wire [1:0]  pick_ch    = pend[0] ? 2'd0 : (pend[1] ? 2'd1 : (pend[2] ? 2'd2 : 2'd3));
    assign take = pick_valid ? (4'h1 << pick_ch) : 4'h0;

    logic             s1_valid;
    logic [1:0]       s1_ch;
    logic [9:0]       s1_avg;
    logic             s1_first;
    logic [3:0]       was_low;
    logic [3:0][8:0]  auto_corr;

    wire [15:0]        target   = {s1_avg, 6'h00};
    wire signed [16:0] diff     = $signed({1'b0, target}) - $signed({1'b0, mbus.rd_data});
    wire signed [16:0] filt_sum = $signed({1'b0, mbus.rd_data}) + (diff >>> FILT_SHIFT);
    wire [15:0]        filt_new = s1_first ? target : filt_sum[15:0];
    wire [9:0]         level    = filt_new[FRAC_BITS +: 10];
    wire               is_low   = level < {4'h0, floor_lim};
    wire               is_high  = level > {3'h0, ceil_lim};
    wire [7:0]         step     = sweep_on ? SWEEP_STEP : NORMAL_STEP;

    assign mbus.rd_en   = pick_valid;
    assign mbus.rd_addr = pick_ch;
    assign mbus.wr_en   = s1_valid;
    assign mbus.wr_addr = s1_ch;
    assign mbus.wr_data = filt_new;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_valid <= 1'b0;
            s1_ch    <= 2'd0;
            s1_avg   <= '0;
            s1_first <= 1'b0;
        end else begin
            s1_valid <= pick_valid;
            s1_ch    <= pick_ch;
            s1_avg   <= avg_hold[pick_ch];
            s1_first <= first[pick_ch] && !restart;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            auto_corr <= '0;
            was_low   <= '0;
        end else if (s1_valid) begin
            if (is_low) begin
                auto_corr[s1_ch] <= step_offset(auto_corr[s1_ch], 1'b1, step);
            end else if (is_high) begin
                auto_corr[s1_ch] <= step_offset(auto_corr[s1_ch], 1'b0, step);
            end
            was_low[s1_ch] <= is_low;
        end
    end

    // The ceiling rises when a colour climbs from below the floor straight past it,
    // which stops the level from bouncing between the two limits.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            floor_lim <= FLOOR_RESET;
            ceil_lim  <= 7'(FLOOR_RESET) + CEIL_MARGIN;
        end else begin
            floor_lim <= next_floor;
            if (override) begin
                ceil_lim <= prog_ceil;
            end else if (restart) begin
                ceil_lim <= ceil_base;
            end else if (sweep_done && !ctrl_reg[KEEP_CEIL_BIT]) begin
                ceil_lim <= ceil_base;
            end else if (s1_valid && was_low[s1_ch] && is_high) begin
                ceil_lim <= (level > 10'h07f) ? 7'h7f : level[6:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Offset stage drive
    // ------------------------------------------------------------------
    wire corr_off    = ctrl_reg[DISABLE_BIT];
    wire corr_manual = ctrl_reg[MANUAL_BIT];
    wire corr_always = ctrl_reg[CONTIN_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chan_offset   <= '0;
            offset_enable <= 1'b0;
        end else begin
            chan_offset   <= corr_off ? '0
                           : (corr_manual ? sh_offset : auto_corr);
            offset_enable <= !corr_off && (corr_always || adc_active);
        end
    end

endmodule : black_level_calibration
`default_nettype wire

// file: logic/blc_pkg.sv
// Constants shared by the black level calibration block.
package blc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]       THRESH_ADDR  = 8'h5f;
    localparam logic [7:0]       CTRL_ADDR    = 8'h62;
    // Channel order: first green, second green, red, blue.
    localparam logic [3:0][7:0]  OFFSET_ADDR  = {8'h64, 8'h63, 8'h61, 8'h60};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FLOOR_LSB     = 0;
    localparam int OVERRIDE_BIT  = 7;
    localparam int CEIL_LSB      = 8;
    localparam int NO_GAIN_BIT   = 15;
    localparam int MANUAL_BIT    = 0;
    localparam int DISABLE_BIT   = 1;
    localparam int CONTIN_BIT    = 2;
    localparam int KEEP_CEIL_BIT = 11;
    localparam int RESTART_BIT   = 12;
    localparam int NO_SWEEP_BIT  = 15;
    localparam int SIGN_BIT      = 8;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [5:0]  FLOOR_RESET   = 6'h04;
    localparam logic [6:0]  CEIL_MARGIN   = 7'h05;
    localparam logic [15:0] THRESH_RESET  = 16'h0904;
    localparam logic [15:0] CTRL_RESET    = 16'h0498;
    localparam logic [8:0]  OFFSET_RESET  = 9'h000;

    // ------------------------------------------------------------------
    // Calibration engine
    // ------------------------------------------------------------------
    localparam logic [7:0]  LAST_PIXEL    = 8'hff;
    localparam int          AVG_SHIFT     = 8;
    localparam int          FRAC_BITS     = 6;
    localparam int          FILT_SHIFT    = 3;
    localparam logic [7:0]  SWEEP_STEP    = 8'h08;
    localparam logic [7:0]  NORMAL_STEP   = 8'h01;
    localparam logic [9:0]  MAG_LIMIT     = 10'h0ff;

    typedef enum logic [1:0] {
        SWEEP_IDLE = 2'b00,
        SWEEP_WAIT = 2'b01,
        SWEEP_RUN  = 2'b10
    } sweep_e;

endpackage : blc_pkg

// file: logic/calib_mem_if.sv
// Port bundle between the calibration engine and its filtered-average store.
`timescale 1ns/1ps
`default_nettype none
interface calib_mem_if;
    logic        rd_en;
    logic [1:0]  rd_addr;
    logic [15:0] rd_data;
    logic        wr_en;
    logic [1:0]  wr_addr;
    logic [15:0] wr_data;

    modport ctrl (output rd_en, output rd_addr, input rd_data,
                  output wr_en, output wr_addr, output wr_data);
    modport mem  (input rd_en, input rd_addr, output rd_data,
                  input wr_en, input wr_addr, input wr_data);
endinterface : calib_mem_if
`default_nettype wire

// file: logic/calib_store.sv
// Four-entry store of per-colour filtered black level averages.
`timescale 1ns/1ps
`default_nettype none
module calib_store (
    // Clock
    input wire logic     ref_clk,
    // Store port
    calib_mem_if.mem     m
);
    logic [15:0] cells [4];

    always_ff @(posedge ref_clk) begin
        if (m.wr_en) begin
            cells[m.wr_addr] <= m.wr_data;
        end
        if (m.rd_en) begin
            m.rd_data <= cells[m.rd_addr];
        end
    end
endmodule : calib_store
`default_nettype wire

// file: verif/black_level_calibration_checker.sv
// Port-level assertions for the black level calibration block.
`timescale 1ns/1ps
`default_nettype none
module black_level_calibration_checker
    import blc_pkg::*;
(
    // Clock and reset
    input wire logic            ref_clk,
    input wire logic            rst,
    // Register port
    input wire logic [7:0]      reg_addr,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [15:0]     reg_wdata,
    input wire logic [15:0]     reg_rdata,
    // Offset stage
    input wire logic            adc_active,
    input wire logic [3:0][8:0] chan_offset,
    input wire logic            offset_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    // A copy of the control register, built from the write strobes alone.
    logic [15:0] ctrl_copy;
    wire         is_offset = (reg_addr >= 8'h60) && (reg_addr <= 8'h64) && (reg_addr != CTRL_ADDR);
    wire         is_mapped = is_offset || (reg_addr == THRESH_ADDR) || (reg_addr == CTRL_ADDR);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_copy <= CTRL_RESET;
        end else if (reg_wr && (reg_addr == CTRL_ADDR)) begin
            ctrl_copy <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_ctrl_rd;
        reg_rd && (reg_addr == CTRL_ADDR);
    endsequence
    sequence s_off_rd;
        reg_rd && is_offset;
    endsequence
    sequence s_bad_rd;
        reg_rd && !is_mapped;
    endsequence

    a_ctrl_readback: assert property (
        s_ctrl_rd |=> reg_rdata == ($past(ctrl_copy) & 16'hefff))
        else $error("control register read back wrong");
    a_restart_self_clear: assert property (s_ctrl_rd |=> !reg_rdata[RESTART_BIT])
        else $error("restart bit did not read as zero");
    a_offset_width: assert property (s_off_rd |=> reg_rdata[15:9] == 7'h00)
        else $error("offset register upper bits not zero");
    a_unmapped_zero: assert property (s_bad_rd |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_disable_zero: assert property (
        ctrl_copy[DISABLE_BIT] |=> !offset_enable && chan_offset == '0)
        else $error("disabled correction still drives an offset");
    a_contin_enable: assert property (
        ctrl_copy[CONTIN_BIT] && !ctrl_copy[DISABLE_BIT] |=> offset_enable)
        else $error("continuous correction not enabled");
    a_adc_enable: assert property (
        ctrl_copy[2:1] == 2'b00 |=> offset_enable == $past(adc_active))
        else $error("correction enable does not follow the converter");
endmodule : black_level_calibration_checker
`default_nettype wire

// file: verif/black_level_calibration_test.sv
// Self-checking testbench for the black level calibration block.
`timescale 1ns/1ps
`default_nettype none
module black_level_calibration_test
    import blc_pkg::*;
;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic            reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [15:0]     reg_wdata = 16'h0000;
    logic [15:0]     reg_rdata, rd_val;
    logic            frame_start = 1'b0, dark_rows_start = 1'b0, adc_active = 1'b1;
    logic            gain_change = 1'b0, timing_change = 1'b0, dark_valid = 1'b0;
    logic [6:0]      max_gain = 7'h00;
    logic [1:0]      dark_chan = 2'h0;
    logic [9:0]      dark_pixel = 10'h000;
    logic [3:0][8:0] chan_offset;
    logic            offset_enable;
    int              bad_count = 0, cmp_count = 0;

    localparam logic [3:0][8:0]  MAN_VAL  = {9'h033, 9'h1ff, 9'h0aa, 9'h105};
    localparam logic [2:0][15:0] MODE_VAL = {16'h049b, 16'h049d, 16'h0499};
    localparam logic [2:0]       MODE_EN  = 3'b010;

    always #20 ref_clk = ~ref_clk;

    black_level_calibration i_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_start(frame_start),
        .dark_rows_start(dark_rows_start), .adc_active(adc_active), .gain_change(gain_change),
        .timing_change(timing_change), .max_gain(max_gain), .dark_valid(dark_valid),
        .dark_chan(dark_chan), .dark_pixel(dark_pixel), .chan_offset(chan_offset),
        .offset_enable(offset_enable)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
    endtask : rd

    // Sends n dark pixels of one colour, then lets the engine settle.
    task feed(input logic [1:0] c, input logic [9:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            dark_valid = 1'b1;
            dark_chan = c;
            dark_pixel = v;
        end
        @(negedge ref_clk);
        dark_valid = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask : feed

    task pulse_drs;
        @(negedge ref_clk);
        dark_rows_start = 1'b1;
        @(negedge ref_clk);
        dark_rows_start = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : pulse_drs

    task conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        rd(THRESH_ADDR);
        check(rd_val, 16'h0904);
        rd(CTRL_ADDR);
        check(rd_val, 16'h0498);
        for (int i = 0; i < 4; i++) begin
            rd(OFFSET_ADDR[i]);
            check(rd_val, 16'h0000);
        end
        rd(8'h65);
        check(rd_val, 16'h0000);
        // Dark averages below the floor raise, above the ceiling lower.
        feed(2'h0, 10'h000, 256);
        check({7'h00, chan_offset[0]}, 16'h0001);
        feed(2'h3, 10'h3ff, 256);
        check({7'h00, chan_offset[3]}, 16'h0101);
        feed(2'h0, 10'h000, 256);
        check({7'h00, chan_offset[0]}, 16'h0002);
        feed(2'h2, 10'h000, 255);
        check({7'h00, chan_offset[2]}, 16'h0000);
        // Every restart cause drops the partial pixel count.
        wr(CTRL_ADDR, 16'h1498);
        rd(CTRL_ADDR);
        check(rd_val, 16'h0498);
        feed(2'h2, 10'h000, 1);
        check({7'h00, chan_offset[2]}, 16'h0000);
        @(negedge ref_clk);
        gain_change = 1'b1;
        @(negedge ref_clk);
        gain_change = 1'b0;
        feed(2'h2, 10'h000, 255);
        check({7'h00, chan_offset[2]}, 16'h0000);
        @(negedge ref_clk);
        timing_change = 1'b1;
        @(negedge ref_clk);
        timing_change = 1'b0;
        feed(2'h2, 10'h000, 1);
        check({7'h00, chan_offset[2]}, 16'h0000);
        feed(2'h2, 10'h000, 255);
        check({7'h00, chan_offset[2]}, 16'h0001);
        // Threshold override, gain dependence and restart reload.
        wr(THRESH_ADDR, 16'h0aa3);
        pulse_drs;
        rd(THRESH_ADDR);
        check(rd_val, 16'h0aa3);
        max_gain = 7'h70;
        wr(THRESH_ADDR, 16'h0904);
        pulse_drs;
        rd(THRESH_ADDR);
        check({10'h000, rd_val[5:0]}, 16'h000b);
        wr(THRESH_ADDR, 16'h8904);
        pulse_drs;
        wr(CTRL_ADDR, 16'h1498);
        rd(THRESH_ADDR);
        check(rd_val, 16'h8904);
        // Programmed offsets wait for the next dark rows.
        wr(CTRL_ADDR, 16'h0499);
        for (int i = 0; i < 4; i++) begin
            wr(OFFSET_ADDR[i], {7'h7f, MAN_VAL[i]});
            rd(OFFSET_ADDR[i]);
            check(rd_val, {7'h00, MAN_VAL[i]});
            check({7'h00, chan_offset[i]}, 16'h0000);
        end
        pulse_drs;
        for (int i = 0; i < 4; i++) begin
            check({7'h00, chan_offset[i]}, {7'h00, MAN_VAL[i]});
        end
        check({15'h0000, offset_enable}, 16'h0001);
        adc_active = 1'b0;
        for (int m = 0; m < 3; m++) begin
            wr(CTRL_ADDR, MODE_VAL[m]);
            repeat (2) @(negedge ref_clk);
            check({15'h0000, offset_enable}, {15'h0000, MODE_EN[m]});
            check(16'(chan_offset[0]), {7'h00, MODE_VAL[m][1] ? 9'h000 : MAN_VAL[0]});
        end
        // A sweep's end restores the ceiling unless bit 11 keeps it.
        for (int k = 0; k < 2; k++) begin
            wr(CTRL_ADDR, 16'h1498);
            wr(THRESH_ADDR, 16'h0f84);
            pulse_drs;
            wr(THRESH_ADDR, 16'h0904);
            pulse_drs;
            wr(CTRL_ADDR, k ? 16'h0498 : 16'h0c98);
            @(negedge ref_clk);
            frame_start = 1'b1;
            @(negedge ref_clk);
            frame_start = 1'b0;
            rd(THRESH_ADDR);
            check(rd_val, k ? 16'h100b : 16'h0f0b);
        end
        // A gain change sweeps only while bit 15 is clear, and a sweep takes large steps.
        for (int k = 0; k < 2; k++) begin
            wr(CTRL_ADDR, k ? 16'h0498 : 16'h8498);
            @(negedge ref_clk);
            gain_change = 1'b1;
            @(negedge ref_clk);
            gain_change = 1'b0;
            pulse_drs;
            feed(2'h1, 10'h000, 256);
            check(16'(chan_offset[1]), k ? 16'h0009 : 16'h0001);
        end
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
endmodule : black_level_calibration_test

bind black_level_calibration black_level_calibration_checker i_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_active(adc_active),
    .chan_offset(chan_offset), .offset_enable(offset_enable)
);
`default_nettype wire
